// ===== logic/counter_mode_sequencer_defines.svh
// register offsets, field positions, reset values and fixed figures of the counter sequencer
// assumes: included by bare name from the package and the design file
`ifndef COUNTER_MODE_SEQUENCER_DEFINES_SVH
`define COUNTER_MODE_SEQUENCER_DEFINES_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define CMS_ADDR_W          3
`define CMS_DATA_W          16

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define CMS_REG_MODE        3'h0
`define CMS_REG_LOAD        3'h1
`define CMS_REG_HOLD        3'h2
`define CMS_REG_COUNT       3'h3
`define CMS_REG_COMMAND     3'h4
`define CMS_REG_STATUS      3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMS_MODE_LSB        0
`define CMS_MODE_MSB        3
`define CMS_CMD_ARM_BIT     0
`define CMS_CMD_DISARM_BIT  1
`define CMS_CMD_LOAD_BIT    2

// ----------------------------------------------------------------
// reset values and counting constants
// ----------------------------------------------------------------
`define CMS_MODE_RESET      4'h0
`define CMS_LOAD_RESET      16'h0000
`define CMS_HOLD_RESET      16'h0000
`define CMS_COUNT_RESET     16'h0000
`define CMS_COUNT_TC_DOWN   16'h0001
`define CMS_COUNT_ONE       16'h0001
`define CMS_DATA_ZERO       16'h0000

`endif

// ===== logic/counter_mode_sequencer_pkg.sv
// types shared by the counter sequencer and its bench
// assumes: the defines header sits beside this file
`include "counter_mode_sequencer_defines.svh"

package counter_mode_sequencer_pkg;

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_C = 4'b0000,
		MODE_D = 4'b0001,
		MODE_E = 4'b0010,
		MODE_F = 4'b0011,
		MODE_G = 4'b0100,
		MODE_H = 4'b0101,
		MODE_I = 4'b0110,
		MODE_J = 4'b0111,
		MODE_K = 4'b1000,
		MODE_L = 4'b1001,
		MODE_N = 4'b1010
	} mode_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic load;
		logic disarm;
		logic arm;
	} command_t;

	typedef struct packed {
		logic [9:0] spare;
		logic       retrigger_pending;
		logic       second_phase;
		logic       triggered;
		logic       armed;
		logic       toggled_terminal_output;
		logic       terminal_count;
	} status_t;

endpackage

// ===== logic/counter_mode_sequencer.sv
// one general-purpose down counter with its mode sequencing, modes C to N
// assumes: gate and source are synchronous to i_clock; one source edge per rising level change
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "counter_mode_sequencer_defines.svh"

// What this block does
// - hardware-triggered strobe: armed, gate edge, count from next source edge to terminal count
// - strobe: at terminal count reload from load register, disarm; rearm then gate edge
// - strobe: gate ignored after triggering edge for rest of that count cycle
// - ungated rate generator: gate ignored, repeat, reload from load at each terminal count
// - level-gated rate generator: as ungated, counting only source edges while gate active
// - one-shot: gate edge starts; terminal count reloads from load, halts, no rearm needed
// - one-shot: further gate activity ignored until terminal count
// - delayed pulse: gate ignored, two terminal counts, hold then load reload, disarm
// - gated delayed pulse: same double sequence, counting only while gate active
// - triggered delayed strobe: gate edge starts, double sequence, gate ignored, disarm
// - ungated duty-cycle: count until disarmed, odd reloads hold, even reloads load
// - level-gated duty-cycle: gate qualifies edges, first reload after arm is hold
// - triggered delayed one-shot: gate edge, hold then load reload, wait next gate edge
// - retriggerable strobe: count while gate active to terminal count, reload, disarm
// - retriggerable strobe: each rising gate edge while armed copies count into hold
// - after retrigger first qualified edge loads count, decrement from the second
// - a qualified source edge is rising and occurs while gate is active
// - toggled output in delayed pulse: initial count sets delay, hold sets width
// - toggled output in duty-cycle mode: load and hold set the duty cycle
// - terminal count on the count after 0001, lasting one source cycle
// - toggled output flips on trailing edge of each terminal count pulse
module counter_mode_sequencer
	import counter_mode_sequencer_pkg::*;
(
	input  wire logic                      i_clock,
	input  wire logic                      i_reset,
	input  wire logic [`CMS_ADDR_W-1:0]    i_address,
	input  wire logic [`CMS_DATA_W-1:0]    i_write_data,
	input  wire logic                      i_write,
	input  wire logic                      i_read,
	output logic      [`CMS_DATA_W-1:0]    o_read_data,
	input  wire logic                      i_gate,
	input  wire logic                      i_source,
	output logic                           o_terminal_count,
	output logic                           o_toggled_terminal_output,
	output logic                           o_armed
);

	// ----------------------------------------------------------------
	// mode classes
	// ----------------------------------------------------------------
	function automatic logic is_legal(input logic [3:0] m);
		return m <= MODE_N;
	endfunction

	function automatic logic is_level_gated(input logic [3:0] m);
		return (m == MODE_E) || (m == MODE_H) || (m == MODE_K) || (m == MODE_N);
	endfunction

	function automatic logic is_edge_triggered(input logic [3:0] m);
		return (m == MODE_C) || (m == MODE_F) || (m == MODE_I) || (m == MODE_L);
	endfunction

	function automatic logic uses_hold(input logic [3:0] m);
		return (m >= MODE_G) && (m <= MODE_L);
	endfunction

	function automatic logic disarms_at_end(input logic [3:0] m);
		return (m == MODE_C) || (m == MODE_G) || (m == MODE_H) || (m == MODE_I) || (m == MODE_N);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [3:0]             mode_r;
	logic [`CMS_DATA_W-1:0] load_r;
	logic [`CMS_DATA_W-1:0] hold_r;
	logic [`CMS_DATA_W-1:0] count_r;
	logic                   armed_r;
	logic                   triggered_r;
	logic                   second_r;
	logic                   pend_r;
	logic                   tc_r;
	logic                   toggle_r;
	logic                   gate_prev_r;
	logic                   src_prev_r;
	logic [`CMS_DATA_W-1:0] read_data_r;

	logic [`CMS_DATA_W-1:0] count_nxt;
	logic [`CMS_DATA_W-1:0] hold_nxt;
	logic [`CMS_DATA_W-1:0] read_data_nxt;
	logic                   armed_nxt;
	logic                   triggered_nxt;
	logic                   second_nxt;
	logic                   pend_nxt;
	logic                   tc_nxt;
	logic                   toggle_nxt;

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	wire      wr_mode  = i_write & (i_address == `CMS_REG_MODE);
	wire      wr_load  = i_write & (i_address == `CMS_REG_LOAD);
	wire      wr_hold  = i_write & (i_address == `CMS_REG_HOLD);
	wire      wr_cmd   = i_write & (i_address == `CMS_REG_COMMAND);

	command_t cmd;
	assign cmd.arm    = wr_cmd & i_write_data[`CMS_CMD_ARM_BIT];
	assign cmd.disarm = wr_cmd & i_write_data[`CMS_CMD_DISARM_BIT];
	assign cmd.load   = wr_cmd & i_write_data[`CMS_CMD_LOAD_BIT];

	// disarm beats arm when both bits are written together
	wire      do_arm    = cmd.arm & ~cmd.disarm;
	wire      do_disarm = cmd.disarm;

	status_t  status;
	assign status.spare                   = '0;
	assign status.retrigger_pending       = pend_r;
	assign status.second_phase            = second_r;
	assign status.triggered               = triggered_r;
	assign status.armed                   = armed_r;
	assign status.toggled_terminal_output = toggle_r;
	assign status.terminal_count          = tc_r;

	wire [`CMS_DATA_W-1:0] mode_word = {12'h000, mode_r};
	wire [`CMS_DATA_W-1:0] read_mux =
		(i_address == `CMS_REG_MODE)   ? mode_word :
		(i_address == `CMS_REG_LOAD)   ? load_r :
		(i_address == `CMS_REG_HOLD)   ? hold_r :
		(i_address == `CMS_REG_COUNT)  ? count_r :
		(i_address == `CMS_REG_STATUS) ? status :
		`CMS_DATA_ZERO;

	// read data stands only in the cycle after the strobe
	assign read_data_nxt = i_read ? read_mux : `CMS_DATA_ZERO;

	// ----------------------------------------------------------------
	// edge detection and counting qualification
	// ----------------------------------------------------------------
	wire gate_rise = i_gate & ~gate_prev_r;
	wire src_rise  = i_source & ~src_prev_r;
	wire mode_n    = (mode_r == MODE_N);

	// level modes need the gate high; edge modes need an accepted trigger
	wire gate_ok =
		is_level_gated(mode_r)    ? i_gate :
		is_edge_triggered(mode_r) ? triggered_r :
		1'b1;

	// a source edge coincident with a retrigger belongs before it, so it is not counted
	wire step = armed_r & is_legal(mode_r) & src_rise & gate_ok & ~(mode_n & gate_rise);

	wire reload_step = step & pend_r;
	wire dec_step    = step & ~pend_r;
	wire tc_event    = dec_step & (count_r == `CMS_COUNT_TC_DOWN);

	// first of a pair reloads from hold, the second from load
	wire use_hold_now = uses_hold(mode_r) & ~second_r;
	wire final_tc     = tc_event & (~uses_hold(mode_r) | second_r);

	// an edge mode accepts one trigger, then ignores the gate until its last terminal count
	wire trigger   = armed_r & is_edge_triggered(mode_r) & ~triggered_r & gate_rise;
	wire retrigger = armed_r & mode_n & gate_rise;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	assign count_nxt =
		cmd.load    ? load_r :
		tc_event    ? (use_hold_now ? hold_r : load_r) :
		reload_step ? load_r :
		dec_step    ? count_r - `CMS_COUNT_ONE :
		count_r;

	// hardware capture wins over a software write in the same cycle
	assign hold_nxt = retrigger ? count_r : (wr_hold ? i_write_data : hold_r);

	assign armed_nxt =
		do_disarm                               ? 1'b0 :
		do_arm                                  ? 1'b1 :
		(final_tc & disarms_at_end(mode_r))     ? 1'b0 :
		armed_r;

	// a gate edge in the cycle of an arm write counts as the trigger only if already armed; only disarm beats it
	assign triggered_nxt =
		do_disarm ? 1'b0 :
		trigger   ? 1'b1 :
		do_arm    ? 1'b0 :
		final_tc  ? 1'b0 :
		triggered_r;

	assign second_nxt =
		do_arm                           ? 1'b0 :
		(tc_event & uses_hold(mode_r))   ? ~second_r :
		second_r;

	assign pend_nxt =
		do_disarm   ? 1'b0 :
		retrigger   ? 1'b1 :
		do_arm      ? 1'b0 :
		reload_step ? 1'b0 :
		pend_r;

	// the pulse lasts until the next source edge
	assign tc_nxt     = tc_event ? 1'b1 : (src_rise ? 1'b0 : tc_r);
	assign toggle_nxt = (tc_r & src_rise) ? ~toggle_r : toggle_r;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			mode_r      <= `CMS_MODE_RESET;
			load_r      <= `CMS_LOAD_RESET;
			hold_r      <= `CMS_HOLD_RESET;
			count_r     <= `CMS_COUNT_RESET;
			read_data_r <= `CMS_DATA_ZERO;
		end else begin
			if (wr_mode) begin
				mode_r <= i_write_data[`CMS_MODE_MSB:`CMS_MODE_LSB];
			end
			if (wr_load) begin
				load_r <= i_write_data;
			end
			hold_r      <= hold_nxt;
			count_r     <= count_nxt;
			read_data_r <= read_data_nxt;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			armed_r     <= 1'b0;
			triggered_r <= 1'b0;
			second_r    <= 1'b0;
			pend_r      <= 1'b0;
			tc_r        <= 1'b0;
			toggle_r    <= 1'b0;
			gate_prev_r <= 1'b0;
			src_prev_r  <= 1'b0;
		end else begin
			armed_r     <= armed_nxt;
			triggered_r <= triggered_nxt;
			second_r    <= second_nxt;
			pend_r      <= pend_nxt;
			tc_r        <= tc_nxt;
			toggle_r    <= toggle_nxt;
			gate_prev_r <= i_gate;
			src_prev_r  <= i_source;
		end
	end

	assign o_read_data               = read_data_r;
	assign o_terminal_count          = tc_r;
	assign o_toggled_terminal_output = toggle_r;
	assign o_armed                   = armed_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_disarmed_holds;
		@(posedge i_clock) disable iff (i_reset)
		(!armed_r && !cmd.load) |=> (count_r == $past(count_r));
	endproperty
	a_disarmed_holds: assert property (p_disarmed_holds) else $error("disarmed counter changed its value");

	property p_strobe_disarms;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_C && tc_event && !cmd.arm && !cmd.load)
			|=> (!armed_r && !triggered_r && count_r == $past(load_r));
	endproperty
	a_strobe_disarms: assert property (p_strobe_disarms) else $error("strobe did not reload and disarm");

	property p_strobe_ignores_gate;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_C && armed_r && triggered_r && !tc_event && !wr_cmd && !wr_mode) |=> triggered_r;
	endproperty
	a_strobe_ignores_gate: assert property (p_strobe_ignores_gate) else $error("trigger lost mid cycle");

	property p_rate_reload;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_D && tc_event && !wr_cmd) |=> (count_r == $past(load_r)) && armed_r == $past(armed_r);
	endproperty
	a_rate_reload: assert property (p_rate_reload) else $error("rate generator reload wrong");

	property p_level_gate_blocks;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_E && !i_gate && !cmd.load) |=> $stable(count_r);
	endproperty
	a_level_gate_blocks: assert property (p_level_gate_blocks) else $error("counted with gate low");

	property p_oneshot_stays_armed;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_F && tc_event && !wr_cmd) |=> (armed_r && !triggered_r);
	endproperty
	a_oneshot_stays_armed: assert property (p_oneshot_stays_armed) else $error("one-shot did not halt armed");

	property p_first_tc_hold;
		@(posedge i_clock) disable iff (i_reset)
		(uses_hold(mode_r) && tc_event && !second_r && !wr_cmd)
			|=> (count_r == $past(hold_r) && second_r);
	endproperty
	a_first_tc_hold: assert property (p_first_tc_hold) else $error("first terminal count not from hold");

	property p_second_tc_load;
		@(posedge i_clock) disable iff (i_reset)
		(uses_hold(mode_r) && tc_event && second_r && !wr_cmd)
			|=> (count_r == $past(load_r) && !second_r);
	endproperty
	a_second_tc_load: assert property (p_second_tc_load) else $error("second terminal count not from load");

	property p_retrigger_capture;
		@(posedge i_clock) disable iff (i_reset)
		(mode_n && armed_r && gate_rise && !wr_cmd) |=> (hold_r == $past(count_r) && pend_r);
	endproperty
	a_retrigger_capture: assert property (p_retrigger_capture) else $error("retrigger did not capture count");

	property p_retrigger_reload;
		@(posedge i_clock) disable iff (i_reset)
		(pend_r && step && !cmd.load) |=> (count_r == $past(load_r) && !pend_r && !tc_r);
	endproperty
	a_retrigger_reload: assert property (p_retrigger_reload) else $error("retrigger reload wrong");

	property p_unqualified_edge;
		@(posedge i_clock) disable iff (i_reset)
		(mode_n && src_rise && !i_gate && !cmd.load) |=> $stable(count_r);
	endproperty
	a_unqualified_edge: assert property (p_unqualified_edge) else $error("unqualified edge counted");

	property p_tc_one_source_cycle;
		@(posedge i_clock) disable iff (i_reset)
		(tc_r && src_rise && !tc_event) |=> (!tc_r && toggle_r != $past(toggle_r));
	endproperty
	a_tc_one_source_cycle: assert property (p_tc_one_source_cycle) else $error("pulse end or toggle wrong");

	property p_toggle_only_on_trailing;
		@(posedge i_clock) disable iff (i_reset)
		!(tc_r && src_rise) |=> $stable(toggle_r);
	endproperty
	a_toggle_only_on_trailing: assert property (p_toggle_only_on_trailing) else $error("stray toggle");

	property p_arm_clears_phase;
		@(posedge i_clock) disable iff (i_reset)
		do_arm |=> (armed_r && !second_r && triggered_r == $past(trigger) && pend_r == $past(retrigger));
	endproperty
	a_arm_clears_phase: assert property (p_arm_clears_phase) else $error("arm did not clear phase");

	property p_edge_wait;
		@(posedge i_clock) disable iff (i_reset)
		(is_edge_triggered(mode_r) && !triggered_r && !cmd.load) |=> $stable(count_r);
	endproperty
	a_edge_wait: assert property (p_edge_wait) else $error("counted before trigger");

	property p_oneshot_gate;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_F && triggered_r && !final_tc && !wr_cmd && !wr_mode) |=> triggered_r;
	endproperty
	a_oneshot_gate: assert property (p_oneshot_gate) else $error("one-shot lost its trigger");

	property p_gated_delay;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_H && !i_gate && !cmd.load) |=> $stable(count_r);
	endproperty
	a_gated_delay: assert property (p_gated_delay) else $error("gated delay counted with gate low");

	property p_delay_strobe_end;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_I && final_tc && !wr_cmd) |=> (!armed_r && !triggered_r && count_r == $past(load_r));
	endproperty
	a_delay_strobe_end: assert property (p_delay_strobe_end) else $error("delayed strobe end wrong");

	property p_delay_oneshot_end;
		@(posedge i_clock) disable iff (i_reset)
		(mode_r == MODE_L && final_tc && !wr_cmd) |=> (armed_r && !triggered_r && count_r == $past(load_r));
	endproperty
	a_delay_oneshot_end: assert property (p_delay_oneshot_end) else $error("delayed one-shot end wrong");

	property p_retrig_strobe_end;
		@(posedge i_clock) disable iff (i_reset)
		(mode_n && tc_event && !wr_cmd) |=> (!armed_r && count_r == $past(load_r));
	endproperty
	a_retrig_strobe_end: assert property (p_retrig_strobe_end) else $error("retrigger strobe end wrong");

endmodule

// ===== tb/gate_source_partner.sv
// external logic on the counting side: gate level and source pulses for one counter
// assumes: the bench asks for a source edge by a one-cycle request; all on i_clock
`timescale 1ns/1ps

module gate_source_partner (
	input  wire logic i_clock,
	input  wire logic i_reset,
	input  wire logic i_gate_level,
	input  wire logic i_source_req,
	output logic      o_gate,
	output logic      o_source
);
	// registered so the counter never sees a gate and a source change from one request
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_gate   <= 1'b0;
			o_source <= 1'b0;
		end else begin
			o_gate   <= i_gate_level;
			o_source <= i_source_req;
		end
	end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the counter sequencer, modes C to N
// assumes: read data one cycle after the read strobe; partner drives gate and source
`timescale 1ns/1ps
`include "counter_mode_sequencer_defines.svh"

module testbench;
	import counter_mode_sequencer_pkg::*;

	logic        i_clock;
	logic        i_reset;
	logic [2:0]  address;
	logic [15:0] write_data;
	logic        write_strobe;
	logic        read_strobe;
	logic [15:0] o_read_data;
	logic        gate_level;
	logic        source_req;
	logic        gate;
	logic        source;
	logic        o_terminal_count;
	logic        o_toggled_terminal_output;
	logic        o_armed;
	logic        exp_tog;
	logic        prev_t;
	int          mismatches;
	int          checked;

	counter_mode_sequencer u_counter_mode_sequencer (
		.i_clock(i_clock), .i_reset(i_reset), .i_address(address), .i_write_data(write_data),
		.i_write(write_strobe), .i_read(read_strobe), .o_read_data(o_read_data), .i_gate(gate),
		.i_source(source), .o_terminal_count(o_terminal_count),
		.o_toggled_terminal_output(o_toggled_terminal_output), .o_armed(o_armed));

	gate_source_partner u_gate_source_partner (
		.i_clock(i_clock), .i_reset(i_reset), .i_gate_level(gate_level),
		.i_source_req(source_req), .o_gate(gate), .o_source(source));

	// ----
	// bus and check helpers
	// ----
	always #5 i_clock = ~i_clock;

	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clock);
		write_strobe <= 1'b1;
		address      <= a;
		write_data   <= d;
		@(posedge i_clock);
		write_strobe <= 1'b0;
	endtask

	task rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge i_clock);
		read_strobe <= 1'b1;
		address     <= a;
		@(posedge i_clock);
		read_strobe <= 1'b0;
		#1 v = o_read_data;
	endtask

	// set the gate, optionally make one source edge, then compare count, arm and outputs
	task step(input logic g, input logic s, input logic [15:0] c, input logic a, input logic t);
		logic [15:0] v;
		@(posedge i_clock);
		gate_level <= g;
		repeat (2) @(posedge i_clock);
		if (s) begin
			source_req <= 1'b1;
			@(posedge i_clock);
			source_req <= 1'b0;
			repeat (2) @(posedge i_clock);
			if (prev_t)
				exp_tog = ~exp_tog;
		end
		prev_t = t;
		rd(`CMS_REG_COUNT, v);
		chk("count", c, v);
		chk("armed", {15'h0000, a}, {15'h0000, o_armed});
		chk("terminal_count", {15'h0000, t}, {15'h0000, o_terminal_count});
		chk("toggled", {15'h0000, exp_tog}, {15'h0000, o_toggled_terminal_output});
	endtask

	// disarm, program, then load and arm in one command
	task cfg(input mode_t m, input logic [15:0] l, input logic [15:0] h);
		@(posedge i_clock);
		gate_level <= 1'b0;
		wr(`CMS_REG_COMMAND, 16'h0002);
		wr(`CMS_REG_MODE, {12'h000, m});
		wr(`CMS_REG_LOAD, l);
		wr(`CMS_REG_HOLD, h);
		wr(`CMS_REG_COMMAND, 16'h0005);
	endtask

	// ----
	// scenarios
	// ----
	task test_regs;
		logic [15:0] v;
		int          a;
		for (a = 0; a < 8; a++) begin
			rd(a[2:0], v);
			chk("reset_read", 16'h0000, v);
		end
		wr(`CMS_REG_MODE, 16'hFFFF);
		rd(`CMS_REG_MODE, v);
		chk("mode", 16'h000F, v);
		wr(`CMS_REG_LOAD, 16'hA5C3);
		rd(`CMS_REG_LOAD, v);
		chk("load", 16'hA5C3, v);
		@(posedge i_clock);
		#1 chk("read_gone", `CMS_DATA_ZERO, o_read_data);
		wr(`CMS_REG_COUNT, 16'h1234);
		rd(`CMS_REG_COUNT, v);
		chk("count_ro", 16'h0000, v);
		wr(3'h7, 16'hFFFF);
		rd(3'h7, v);
		chk("unmapped", 16'h0000, v);
		$display("test registers done");
	endtask

	task test_c;
		cfg(MODE_C, 16'h0002, 16'h0000);
		step(0, 1, 16'h0002, 1, 0);
		step(1, 0, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(0, 0, 16'h0001, 1, 0);
		step(1, 0, 16'h0001, 1, 0);
		step(1, 1, 16'h0002, 0, 1);
		step(0, 1, 16'h0002, 0, 0);
		step(1, 0, 16'h0002, 0, 0);
		wr(`CMS_REG_COMMAND, 16'h0001);
		step(1, 1, 16'h0002, 1, 0);
		step(0, 0, 16'h0002, 1, 0);
		step(1, 0, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		$display("test mode C done");
	endtask

	task test_de;
		cfg(MODE_D, 16'h0002, 16'h0000);
		step(1, 1, 16'h0001, 1, 0);
		step(0, 1, 16'h0002, 1, 1);
		step(1, 1, 16'h0001, 1, 0);
		step(0, 1, 16'h0002, 1, 1);
		cfg(MODE_E, 16'h0003, 16'h0000);
		step(0, 1, 16'h0003, 1, 0);
		step(1, 1, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(1, 1, 16'h0003, 1, 1);
		$display("test modes D E done");
	endtask

	task test_f;
		cfg(MODE_F, 16'h0002, 16'h0000);
		step(0, 1, 16'h0002, 1, 0);
		step(1, 0, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(0, 0, 16'h0001, 1, 0);
		step(1, 0, 16'h0001, 1, 0);
		step(1, 1, 16'h0002, 1, 1);
		step(1, 1, 16'h0002, 1, 0);
		step(0, 0, 16'h0002, 1, 0);
		step(1, 0, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		$display("test mode F done");
	endtask

	task test_gh;
		cfg(MODE_G, 16'h0002, 16'h0001);
		step(1, 1, 16'h0001, 1, 0);
		step(0, 1, 16'h0001, 1, 1);
		step(0, 1, 16'h0002, 0, 1);
		step(0, 1, 16'h0002, 0, 0);
		wr(`CMS_REG_COMMAND, 16'h0001);
		step(0, 1, 16'h0001, 1, 0);
		cfg(MODE_H, 16'h0002, 16'h0001);
		step(0, 1, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(1, 1, 16'h0001, 1, 1);
		step(1, 1, 16'h0002, 0, 1);
		$display("test modes G H done");
	endtask

	task test_i;
		cfg(MODE_I, 16'h0002, 16'h0001);
		step(0, 1, 16'h0002, 1, 0);
		step(1, 0, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(0, 0, 16'h0001, 1, 0);
		step(1, 1, 16'h0001, 1, 1);
		step(0, 1, 16'h0002, 0, 1);
		step(0, 1, 16'h0002, 0, 0);
		$display("test mode I done");
	endtask

	task test_jk;
		cfg(MODE_J, 16'h0002, 16'h0003);
		step(0, 1, 16'h0001, 1, 0);
		step(1, 1, 16'h0003, 1, 1);
		step(0, 1, 16'h0002, 1, 0);
		step(0, 1, 16'h0001, 1, 0);
		step(0, 1, 16'h0002, 1, 1);
		wr(`CMS_REG_COMMAND, 16'h0002);
		step(0, 1, 16'h0002, 0, 0);
		cfg(MODE_K, 16'h0002, 16'h0003);
		step(0, 1, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(1, 1, 16'h0003, 1, 1);
		step(1, 1, 16'h0002, 1, 0);
		wr(`CMS_REG_COMMAND, 16'h0001);
		step(1, 1, 16'h0001, 1, 0);
		step(1, 1, 16'h0003, 1, 1);
		$display("test modes J K done");
	endtask

	task test_l;
		cfg(MODE_L, 16'h0002, 16'h0003);
		step(0, 1, 16'h0002, 1, 0);
		step(1, 0, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(0, 0, 16'h0001, 1, 0);
		step(1, 0, 16'h0001, 1, 0);
		step(1, 1, 16'h0003, 1, 1);
		step(1, 1, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(1, 1, 16'h0002, 1, 1);
		step(1, 1, 16'h0002, 1, 0);
		step(0, 0, 16'h0002, 1, 0);
		step(1, 0, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		$display("test mode L done");
	endtask

	task test_n;
		logic [15:0] v;
		cfg(MODE_N, 16'h0003, 16'h0000);
		step(0, 1, 16'h0003, 1, 0);
		step(1, 1, 16'h0003, 1, 0);
		rd(`CMS_REG_HOLD, v);
		chk("hold", 16'h0003, v);
		step(1, 1, 16'h0002, 1, 0);
		step(0, 0, 16'h0002, 1, 0);
		step(1, 0, 16'h0002, 1, 0);
		rd(`CMS_REG_HOLD, v);
		chk("hold", 16'h0002, v);
		rd(`CMS_REG_STATUS, v);
		chk("status", {10'h000, 1'b1, 2'b00, 1'b1, exp_tog, 1'b0}, v);
		step(1, 1, 16'h0003, 1, 0);
		step(1, 1, 16'h0002, 1, 0);
		step(1, 1, 16'h0001, 1, 0);
		step(1, 1, 16'h0003, 0, 1);
		step(1, 1, 16'h0003, 0, 0);
		$display("test mode N done");
	endtask

	// ----
	// main sequence and hang guard
	// ----
	initial begin
		i_clock = 1'b0;
		i_reset = 1'b1;
		address = 3'h0;
		write_data = 16'h0000;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
		gate_level = 1'b0;
		source_req = 1'b0;
		exp_tog = 1'b0;
		prev_t = 1'b0;
		mismatches = 0;
		checked = 0;
		repeat (3) @(posedge i_clock);
		i_reset <= 1'b0;
		test_regs;
		test_c;
		test_de;
		test_f;
		test_gh;
		test_i;
		test_jk;
		test_l;
		test_n;
		report_and_stop;
	end

	initial begin
		repeat (20000) @(posedge i_clock);
		mismatches++;
		report_and_stop;
	end
endmodule
